/* File: design/uer_pkg.sv */
// Shared constants and types for the endpoint mode responder.
package uer_pkg;
  // ----------------------------------------
  // Endpoint mode codes
  // ----------------------------------------
  localparam logic [3:0] MODE_DISABLED = 4'h0;
  localparam logic [3:0] MODE_NAK_IN_OUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_IN_OUT = 4'h3;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_ACK_OUT_STATUS_IN = 4'hb;
  localparam logic [3:0] MODE_NAK_IN = 4'hc;
  localparam logic [3:0] MODE_ACK_IN = 4'hd;
  localparam logic [3:0] MODE_ACK_IN_STATUS_OUT = 4'hf;
  // ----------------------------------------
  // Token and handshake encodings
  // ----------------------------------------
  localparam logic [1:0] PID_SETUP = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_OUT = 2'h2;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MODE_ACK_BIT = 4;
  localparam int MODE_OUT_BIT = 5;
  localparam int MODE_IN_BIT = 6;
  localparam int MODE_SETUP_BIT = 7;
  localparam int CNT_TOG_BIT = 7;
  localparam int CNT_VAL_BIT = 6;
  localparam int CFG_NAK_EN_BIT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE_BASE = 8'h00;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h10;
  localparam logic [7:0] ADDR_CFG = 8'h20;
  localparam logic [7:0] ADDR_BUF_BASE = 8'h40;
  // ----------------------------------------
  // Packet length limits
  // ----------------------------------------
  localparam logic [4:0] CTRL_MAX_LEN = 5'h0a;
  localparam logic [4:0] STATUS_LEN = 5'h02;
  typedef enum {ST_IDLE, ST_RX, ST_TXLOAD, ST_WAITACK} uer_state_e;
endpackage

/* File: design/uer_responder.sv */
// Endpoint mode responder of the bus interface engine, with its transmit FIFO.
// ----------------------------------------
// ----------------------------------------
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// ----------------------------------------
// Shift-register FIFO; head and flags are flops.
// ----------------------------------------
module uer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // Device clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Room for one word.
  input wire logic [WIDTH-1:0] in_data, // Word to write.
  output logic out_valid, // Head word present.
  input wire logic out_ready, // Head word taken.
  output logic [WIDTH-1:0] out_data // Head word.
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [0:DEPTH-1]; // Entry 0 is the head.
  logic [CW-1:0] cnt; // Words held.
  logic push; // Word accepted this cycle.
  logic pop; // Word drained this cycle.
  logic [CW-1:0] next_cnt; // Fill after this cycle.

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_cnt = cnt + CW'(push) - CW'(pop);
  assign out_data = mem[0];

  // Count and flags move together.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      cnt <= next_cnt;
      in_ready <= (next_cnt != CW'(DEPTH));
      out_valid <= (next_cnt != '0);
    end
  end

  // Each entry shifts down on a pop and takes the new word at its slot.
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mem[i] <= '0;
      end else if (push && (CW'(i) == (pop ? cnt - CW'(1) : cnt))) begin
        mem[i] <= in_data;
      end else if (pop) begin
        mem[i] <= (i == DEPTH - 1) ? '0 : mem[(i + 1) % DEPTH];
      end
    end
  end
endmodule // uer_fifo

// ----------------------------------------
// Responder top
// ----------------------------------------
module uer_responder #(
  parameter int NUM_EP = 3,
  parameter logic [4:0] DATA_MAX_LEN = 5'h08,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk, // Device clock, 100 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire logic tok_valid, // Token received, one-cycle pulse.
  input wire logic [1:0] tok_pid, // Token kind.
  input wire logic [1:0] tok_ep, // Token endpoint.
  input wire logic rx_valid, // Data byte received.
  input wire logic [7:0] rx_data, // Received byte.
  input wire logic rx_end, // Data packet ended, pulse.
  input wire logic rx_ok, // Packet passed its checks.
  input wire logic rx_toggle, // Data toggle of the packet.
  input wire logic host_ack, // Host acknowledged our data.
  output logic hs_valid, // Send a handshake, pulse.
  output logic [1:0] hs_code, // Handshake kind.
  output logic tx_start, // Data packet begins, pulse.
  output logic [3:0] tx_len, // Bytes in that packet.
  output logic tx_toggle, // Data toggle of that packet.
  output logic tx_valid, // Transmit byte present.
  input wire logic tx_ready, // Transmitter took the byte.
  output logic [7:0] tx_data, // Transmit byte.
  output logic [NUM_EP-1:0] ep_event // Endpoint event, pulse.
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] mode_reg [0:NUM_EP-1]; // Status bits over mode code.
  logic [7:0] cnt_reg [0:NUM_EP-1]; // Toggle, valid, byte count.
  logic [7:0] buf_mem [0:NUM_EP-1][0:15]; // Packet bytes.
  logic [7:0] cfg_reg; // Stall bits low, NAK event enable.
  uer_pkg::uer_state_e state; // Transaction phase.
  logic [1:0] cur_ep; // Endpoint of the open transaction.
  logic [1:0] cur_pid; // Token of the open transaction.
  logic [4:0] rx_len; // Bytes seen, saturating.
  logic [3:0] tx_idx; // Next byte to queue.
  logic fifo_ready; // FIFO has room.

  // ----------------------------------------
  // Decision logic
  // ----------------------------------------
  logic [1:0] sel_ep; // Endpoint being judged.
  logic [3:0] m; // Its mode code.
  logic stall; // Its stall bit.
  logic ctl; // It is the control endpoint.
  logic good; // Packet valid and within size.
  logic in_tok; // IN token to judge now.
  logic pkt_end; // SETUP or OUT data complete.
  logic ack_in; // Host ACK for our data.
  logic act; // Endpoint state changes.
  logic hs_go; // Handshake to send.
  logic [1:0] hs_sel; // Handshake kind.
  logic mode_wr; // Mode code changes.
  logic [3:0] mode_new; // New mode code.
  logic [3:0] set_bits; // Setup, in, out, ack bits to set.
  logic cnt_wr; // Count register changes.
  logic [7:0] cnt_new; // New count register value.
  logic ev; // Raise endpoint event.
  logic tx_go; // Start a data packet.
  logic tx_zero; // That packet is zero length.

  assign in_tok = tok_valid && (tok_pid == uer_pkg::PID_IN) && (state != uer_pkg::ST_RX)
    && (state != uer_pkg::ST_TXLOAD);
  assign pkt_end = (state == uer_pkg::ST_RX) && rx_end;
  assign ack_in = (state == uer_pkg::ST_WAITACK) && host_ack;
  assign sel_ep = in_tok ? tok_ep : cur_ep;
  assign m = mode_reg[sel_ep][3:0];
  assign stall = cfg_reg[sel_ep];
  assign ctl = (sel_ep == 2'h0);
  assign good = rx_ok && (rx_len <= (ctl ? uer_pkg::CTRL_MAX_LEN : DATA_MAX_LEN));

  // One judgement per cycle: an IN token, a finished packet or a host ACK.
  always_comb begin
    act = 1'b0;
    hs_go = 1'b0;
    hs_sel = uer_pkg::HS_ACK;
    mode_wr = 1'b0;
    mode_new = m;
    set_bits = 4'h0;
    cnt_wr = 1'b0;
    cnt_new = {rx_toggle, 1'b1, 2'b00, rx_len[3:0]};
    ev = 1'b0;
    tx_go = 1'b0;
    tx_zero = 1'b0;
    if (in_tok) begin
      if (ctl) begin
        case (m)
          uer_pkg::MODE_STALL_IN_OUT: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_STALL;
          end
          uer_pkg::MODE_STATUS_OUT: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_STALL;
            mode_wr = 1'b1;
            mode_new = uer_pkg::MODE_STALL_IN_OUT;
            ev = 1'b1;
          end
          uer_pkg::MODE_NAK_IN_OUT: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_NAK;
          end
          uer_pkg::MODE_ACK_OUT_STATUS_IN, uer_pkg::MODE_STATUS_IN: begin
            tx_go = 1'b1;
            tx_zero = 1'b1;
          end
          uer_pkg::MODE_ACK_IN_STATUS_OUT: tx_go = 1'b1;
          default: ;
        endcase
      end else if (m == uer_pkg::MODE_ACK_IN) begin
        hs_go = stall;
        hs_sel = uer_pkg::HS_STALL;
        tx_go = !stall;
      end else if (m == uer_pkg::MODE_NAK_IN) begin
        hs_go = 1'b1;
        hs_sel = uer_pkg::HS_NAK;
        ev = cfg_reg[uer_pkg::CFG_NAK_EN_BIT];
      end
    end else if (pkt_end && good) begin
      // Oversized or damaged packets fall through here and are ignored.
      if (cur_pid == uer_pkg::PID_SETUP) begin
        if (ctl && (m != uer_pkg::MODE_DISABLED)) begin
          hs_go = 1'b1;
          mode_wr = 1'b1;
          mode_new = uer_pkg::MODE_NAK_IN_OUT;
          set_bits = 4'h9;
          cnt_wr = 1'b1;
          ev = 1'b1;
        end
      end else if (ctl) begin
        case (m)
          uer_pkg::MODE_STALL_IN_OUT: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_STALL;
          end
          uer_pkg::MODE_NAK_IN_OUT: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_NAK;
          end
          uer_pkg::MODE_STATUS_OUT, uer_pkg::MODE_ACK_IN_STATUS_OUT: begin
            hs_go = 1'b1;
            ev = 1'b1;
            if (rx_len == uer_pkg::STATUS_LEN && rx_toggle) begin
              set_bits = 4'h3;
              cnt_wr = 1'b1;
              cnt_new = {1'b1, 1'b1, 2'b00, uer_pkg::STATUS_LEN[3:0]};
              mode_wr = 1'b1;
              mode_new = uer_pkg::MODE_STATUS_OUT;
            end else begin
              hs_sel = uer_pkg::HS_STALL;
              mode_wr = 1'b1;
              mode_new = uer_pkg::MODE_STALL_IN_OUT;
            end
          end
          uer_pkg::MODE_ACK_OUT_STATUS_IN: begin
            hs_go = 1'b1;
            set_bits = 4'h3;
            mode_wr = 1'b1;
            mode_new = uer_pkg::MODE_NAK_IN_OUT;
            cnt_wr = 1'b1;
            ev = 1'b1;
          end
          uer_pkg::MODE_STATUS_IN: begin
            hs_go = 1'b1;
            hs_sel = uer_pkg::HS_STALL;
            mode_wr = 1'b1;
            mode_new = uer_pkg::MODE_STALL_IN_OUT;
            ev = 1'b1;
          end
          default: ;
        endcase
      end else if (m == uer_pkg::MODE_ACK_OUT) begin
        hs_go = 1'b1;
        if (stall) begin
          hs_sel = uer_pkg::HS_STALL;
        end else begin
          set_bits = 4'h1;
          mode_wr = 1'b1;
          mode_new = uer_pkg::MODE_NAK_OUT;
          cnt_wr = 1'b1;
          ev = 1'b1;
        end
      end else if (m == uer_pkg::MODE_NAK_OUT) begin
        hs_go = 1'b1;
        hs_sel = uer_pkg::HS_NAK;
        ev = cfg_reg[uer_pkg::CFG_NAK_EN_BIT];
      end
    end else if (ack_in) begin
      if (ctl && (m == uer_pkg::MODE_ACK_OUT_STATUS_IN || m == uer_pkg::MODE_STATUS_IN
          || m == uer_pkg::MODE_ACK_IN_STATUS_OUT)) begin
        set_bits = 4'h5;
        mode_wr = 1'b1;
        mode_new = (m == uer_pkg::MODE_ACK_IN_STATUS_OUT) ? uer_pkg::MODE_NAK_IN_OUT
          : uer_pkg::MODE_STALL_IN_OUT;
        ev = 1'b1;
      end else if (!ctl && m == uer_pkg::MODE_ACK_IN) begin
        set_bits = 4'h1;
        mode_wr = 1'b1;
        mode_new = uer_pkg::MODE_NAK_IN;
        ev = 1'b1;
      end
    end
    act = mode_wr || cnt_wr || (set_bits != 4'h0);
  end

  // ----------------------------------------
  // Transaction sequencer
  // ----------------------------------------
  // A new token wins in ST_IDLE or ST_WAITACK only: a host that never ACKs our data simply moves on.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= uer_pkg::ST_IDLE;
      cur_ep <= 2'h0;
      cur_pid <= uer_pkg::PID_SETUP;
      tx_idx <= 4'h0;
      tx_len <= 4'h0;
      tx_toggle <= 1'b0;
      tx_start <= 1'b0;
    end else begin
      tx_start <= tx_go;
      if (tx_go) begin
        tx_len <= tx_zero ? 4'h0 : cnt_reg[sel_ep][3:0];
        tx_toggle <= cnt_reg[sel_ep][uer_pkg::CNT_TOG_BIT];
        tx_idx <= 4'h0;
        cur_ep <= sel_ep;
        // An empty count must not wrap the byte index into sixteen bytes.
        state <= (tx_zero || cnt_reg[sel_ep][3:0] == 4'h0) ? uer_pkg::ST_WAITACK
          : uer_pkg::ST_TXLOAD;
      end else if (tok_valid && (state == uer_pkg::ST_IDLE || state == uer_pkg::ST_WAITACK)) begin
        cur_ep <= tok_ep;
        cur_pid <= tok_pid;
        state <= (tok_pid == uer_pkg::PID_IN) ? uer_pkg::ST_IDLE : uer_pkg::ST_RX;
      end else if (pkt_end || ack_in) begin
        state <= uer_pkg::ST_IDLE;
      end else if (state == uer_pkg::ST_TXLOAD && fifo_ready) begin
        tx_idx <= tx_idx + 4'h1;
        if (tx_idx + 4'h1 == tx_len) begin
          state <= uer_pkg::ST_WAITACK;
        end
      end
    end
  end

  // Received byte counter saturates so oversized packets stay oversized.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_len <= 5'h00;
    end else if (tok_valid) begin
      rx_len <= 5'h00;
    end else if (state == uer_pkg::ST_RX && rx_valid && rx_len != 5'h1f) begin
      rx_len <= rx_len + 5'h01;
    end
  end

  // Handshake and event pulses.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hs_valid <= 1'b0;
      hs_code <= uer_pkg::HS_ACK;
      ep_event <= '0;
    end else begin
      hs_valid <= hs_go;
      hs_code <= hs_sel;
      ep_event <= ev ? NUM_EP'(1) << sel_ep : '0;
    end
  end

  // ----------------------------------------
  // Endpoint registers and buffers
  // ----------------------------------------
  // firmware rewrites mode
  // Engine updates beat a same-cycle firmware write, so no event is lost.
  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mode_reg[e] <= uer_pkg::REG_RESET;
      end else if (act && sel_ep == 2'(e)) begin
        mode_reg[e] <= {mode_reg[e][7:4] | set_bits, mode_wr ? mode_new : mode_reg[e][3:0]};
      end else if (reg_wr && reg_addr == uer_pkg::ADDR_MODE_BASE + 8'(e)) begin
        mode_reg[e] <= reg_wdata;
      end
    end
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_reg[e] <= uer_pkg::REG_RESET;
      end else if (cnt_wr && sel_ep == 2'(e)) begin
        cnt_reg[e] <= cnt_new;
      end else if (reg_wr && reg_addr == uer_pkg::ADDR_CNT_BASE + 8'(e)) begin
        cnt_reg[e] <= reg_wdata & 8'hcf;
      end
    end
    // Bytes land as they arrive; a rejected packet leaves junk behind.
    for (genvar b = 0; b < 16; b++) begin : g_byte
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          buf_mem[e][b] <= uer_pkg::REG_RESET;
        end else if (state == uer_pkg::ST_RX && rx_valid && cur_ep == 2'(e)
            && rx_len == 5'(b)) begin
          buf_mem[e][b] <= rx_data;
        end else if (reg_wr && reg_addr == uer_pkg::ADDR_BUF_BASE + 8'(e * 16 + b)) begin
          buf_mem[e][b] <= reg_wdata;
        end
      end
    end
  end

  // Configuration: stall bits of the data endpoints (the control endpoint ignores its bit) and the NAK event enable.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_reg <= uer_pkg::REG_RESET;
    end else if (reg_wr && reg_addr == uer_pkg::ADDR_CFG) begin
      cfg_reg <= reg_wdata;
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr >= uer_pkg::ADDR_BUF_BASE
        && reg_addr < uer_pkg::ADDR_BUF_BASE + 8'(NUM_EP * 16)) begin
      reg_rdata <= buf_mem[2'((reg_addr - uer_pkg::ADDR_BUF_BASE) >> 4)][reg_addr[3:0]];
    end else if (reg_addr >= uer_pkg::ADDR_MODE_BASE
        && reg_addr < uer_pkg::ADDR_MODE_BASE + 8'(NUM_EP)) begin
      reg_rdata <= mode_reg[2'(reg_addr - uer_pkg::ADDR_MODE_BASE)];
    end else if (reg_addr >= uer_pkg::ADDR_CNT_BASE
        && reg_addr < uer_pkg::ADDR_CNT_BASE + 8'(NUM_EP)) begin
      reg_rdata <= cnt_reg[2'(reg_addr - uer_pkg::ADDR_CNT_BASE)];
    end else if (reg_addr == uer_pkg::ADDR_CFG) begin
      reg_rdata <= cfg_reg;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  // A stalled transmitter holds the sequencer in its loading phase.
  uer_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .mclk(mclk),
    .rst(rst),
    .in_valid(state == uer_pkg::ST_TXLOAD),
    .in_ready(fifo_ready),
    .in_data(buf_mem[cur_ep][tx_idx]),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule // uer_responder

/* File: tb/uer_host.sv */
// Host model: tokens, OUT data and handshakes.
`timescale 1ns/1ps
module uer_host (
  input wire logic mclk, // Device clock.
  output logic tok_valid, // Token pulse.
  output logic [1:0] tok_pid, // Token kind.
  output logic [1:0] tok_ep, // Token endpoint.
  output logic rx_valid, // Byte strobe.
  output logic [7:0] rx_data, // Byte value.
  output logic rx_end, // Packet end pulse.
  output logic rx_ok, // Packet good.
  output logic rx_toggle, // Packet toggle.
  output logic host_ack, // Host accepted our data.
  output logic tx_ready // Host took a byte.
);
  logic [1:0] pace = 2'h0; // Stall pacer.
  initial begin
    {tok_valid, tok_pid, tok_ep, rx_valid, rx_end, rx_ok, rx_toggle, host_ack} = '0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Takes one byte in four so the FIFO backs up.
  always @(posedge mclk) begin
    pace <= pace + 2'h1;
    tx_ready <= (pace == 2'h3);
  end
  // One token pulse.
  task automatic token(input logic [1:0] pid, input logic [1:0] ep);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_ep <= ep;
    @(posedge mclk);
    tok_valid <= 1'b0;
  endtask
  // n-byte data packet; the line is scrambled once released.
  task automatic data(input int n, input logic ok, input logic tog);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= 8'ha5 ^ 8'(i);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_ok <= ok;
    rx_toggle <= tog;
    @(posedge mclk);
    rx_end <= 1'b0;
    rx_ok <= 1'b0;
  endtask
  // The host's ACK of a data packet we sent.
  task automatic ack();
    @(posedge mclk);
    host_ack <= 1'b1;
    @(posedge mclk);
    host_ack <= 1'b0;
  endtask
endmodule // uer_host

/* File: tb/uer_responder_sva.sv */
// Concurrent checks on the responder's ports.
`timescale 1ns/1ps
module uer_responder_chk #(
  parameter int NUM_EP = 3
) (
  input wire logic mclk, // Device clock.
  input wire logic rst, // Reset.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [7:0] reg_rdata, // Read data.
  input wire logic tok_valid, // Token pulse.
  input wire logic [1:0] tok_pid, // Token kind.
  input wire logic rx_end, // Packet end.
  input wire logic rx_ok, // Packet good.
  input wire logic host_ack, // Host ACK.
  input wire logic hs_valid, // Handshake pulse.
  input wire logic [1:0] hs_code, // Handshake kind.
  input wire logic tx_start, // Packet start.
  input wire logic [3:0] tx_len, // Packet length.
  input wire logic tx_valid, // Byte present.
  input wire logic tx_ready, // Byte taken.
  input wire logic [NUM_EP-1:0] ep_event // Events.
);
  logic nak_en; // Shadow of the NAK event enable.
  logic in_d; // An IN token was seen last cycle.
  logic [4:0] sent; // Bytes taken since the last packet start.
  // Shadows, so nothing inside is peeked at.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nak_en <= 1'b0;
      in_d <= 1'b0;
    end else begin
      in_d <= tok_valid && tok_pid == uer_pkg::PID_IN;
      if (reg_wr && reg_addr == uer_pkg::ADDR_CFG) nak_en <= reg_wdata[uer_pkg::CFG_NAK_EN_BIT];
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) sent <= 5'h00;
    else if (tx_start) sent <= 5'h00;
    else if (tx_valid && tx_ready) sent <= sent + 5'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_bad_pkt; rx_end && !rx_ok; endsequence
  sequence s_zero_tx; tx_start && tx_len == 4'h0; endsequence
  AST_BAD_IGNORED: assert property (s_bad_pkt |=> !hs_valid && ep_event == '0)
    else $error("answer to a bad packet");
  AST_HS_CAUSE: assert property (hs_valid |-> $past(rx_end) || $past(tok_valid))
    else $error("handshake without a cause");
  AST_TX_CAUSE: assert property (tx_start |-> in_d)
    else $error("packet start without IN");
  AST_ZERO_LEN: assert property (s_zero_tx |=> !tx_valid [*3])
    else $error("bytes in a zero-length packet");
  AST_TX_COUNT: assert property (tx_valid && tx_ready |-> sent < {1'b0, tx_len})
    else $error("too many bytes sent");
  AST_ACK_FULL: assert property (host_ack |-> sent == {1'b0, tx_len})
    else $error("too few bytes sent");
  AST_EVT_CAUSE: assert property (ep_event != '0 |-> hs_valid || $past(host_ack))
    else $error("event without a cause");
  AST_EVT_ONE: assert property ($onehot0(ep_event))
    else $error("two events at once");
  AST_NAK_QUIET: assert property (hs_valid && hs_code == uer_pkg::HS_NAK && !nak_en
      |-> ep_event == '0)
    else $error("NAK event while disabled");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule // uer_responder_chk

/* File: tb/tb.sv */
// Self-checking bench for the endpoint mode responder.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t mismatch got %h", $time, a); end end
module tb;
  logic mclk = 1'b0; // Device clock.
  logic rst = 1'b1; // Reset.
  logic reg_wr = 1'b0; // Write strobe.
  logic reg_rd = 1'b0; // Read strobe.
  logic rd_d = 1'b0; // Read taken, data due.
  logic [7:0] reg_addr = 8'h00; // Address.
  logic [7:0] reg_wdata = 8'h00; // Write data.
  logic [7:0] lfsr = 8'h48; // Random source.
  logic [7:0] reg_rdata, rx_data, tx_data; // Data paths.
  logic tok_valid, rx_valid, rx_end, rx_ok, rx_toggle, host_ack; // Host side.
  logic hs_valid, tx_start, tx_toggle, tx_valid, tx_ready; // Answers.
  logic [1:0] tok_pid, tok_ep, hs_code; // Codes.
  logic [3:0] tx_len; // Packet length.
  logic [2:0] ep_event; // Events.
  logic [7:0] q_rd[$], q_by[$]; // Expected reads and bytes.
  logic [1:0] q_hs[$]; // Expected handshakes.
  logic [4:0] q_len[$]; // Expected toggle and length.
  int bad_count = 0, samples_checked = 0, cyc = 0; // Tallies.
  uer_responder uut (.mclk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tok_valid, .tok_pid, .tok_ep,
    .rx_valid, .rx_data, .rx_end, .rx_ok, .rx_toggle, .host_ack, .hs_valid, .hs_code,
    .tx_start, .tx_len, .tx_toggle, .tx_valid, .tx_ready, .tx_data, .ep_event);
  uer_host h (.mclk, .tok_valid, .tok_pid, .tok_ep, .rx_valid, .rx_data, .rx_end, .rx_ok,
    .rx_toggle, .host_ack, .tx_ready);
  always #5 mclk = ~mclk;
  // Hang guard.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // Results are settled at the falling edge; each takes the oldest note.
  always @(negedge mclk) begin
    if (rd_d) `CHK(reg_rdata, q_rd.pop_front())
    rd_d = reg_rd;
    if (hs_valid) `CHK(hs_code, q_hs.pop_front())
    if (tx_start) `CHK({tx_toggle, tx_len}, q_len.pop_front())
    if (tx_valid && tx_ready) `CHK(tx_data, q_by.pop_front())
  end
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q_rd.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Token, data for SETUP/OUT, expected handshake (code 3: none).
  task automatic pkt(input logic [1:0] pid, input logic [1:0] ep, input int n,
      input logic ok, input logic tog, input logic [1:0] code);
    if (code != 2'h3) q_hs.push_back(code);
    h.token(pid, ep);
    if (pid != uer_pkg::PID_IN) h.data(n, ok, tog);
    wt(4);
  endtask
  // Firmware loads random bytes and the count.
  task automatic load(input logic [1:0] ep, input logic [3:0] n);
    for (int i = 0; i < n; i++) begin
      lfsr = nxt(lfsr);
      q_by.push_back(lfsr);
      wr(uer_pkg::ADDR_BUF_BASE + {ep, 4'h0} + 8'(i), lfsr);
    end
    wr(uer_pkg::ADDR_CNT_BASE + 8'(ep), {4'h0, n});
    q_len.push_back({1'b0, n});
  endtask
  task automatic summarize();
    bad_count += q_hs.size() + q_len.size() + q_by.size() + q_rd.size();
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wt(2);
    rd(8'h30, 8'h00);
    wr(8'h00, 8'h03);
    pkt(2'h0, 2'h0, 11, 1'b1, 1'b0, 2'h3);
    pkt(2'h0, 2'h0, 8, 1'b0, 1'b0, 2'h3);
    pkt(2'h0, 2'h0, 8, 1'b1, 1'b0, uer_pkg::HS_ACK);
    rd(8'h00, 8'h91);
    rd(8'h10, 8'h48);
    rd(8'h40, 8'ha5);
    $display("setup test done");
    wr(8'h00, 8'h02);
    pkt(2'h2, 2'h0, 2, 1'b1, 1'b0, uer_pkg::HS_STALL);
    rd(8'h00, 8'h03);
    wr(8'h00, 8'h02);
    pkt(2'h2, 2'h0, 2, 1'b1, 1'b1, uer_pkg::HS_ACK);
    rd(8'h00, 8'h32);
    rd(8'h10, 8'hc2);
    wr(8'h00, 8'h0b);
    pkt(2'h2, 2'h0, 11, 1'b1, 1'b1, 2'h3);
    pkt(2'h2, 2'h0, 5, 1'b1, 1'b1, uer_pkg::HS_ACK);
    rd(8'h00, 8'h31);
    rd(8'h10, 8'hc5);
    // zero-length IN, state moves only on host ACK
    foreach (lfsr[i]) if (i < 2) begin
      wr(8'h00, i ? 8'h06 : 8'h0b);
      q_len.push_back(5'h10);
      pkt(2'h1, 2'h0, 0, 1'b0, 1'b0, 2'h3);
      rd(8'h00, i ? 8'h06 : 8'h0b);
      q_len.push_back(5'h10);
      pkt(2'h1, 2'h0, 0, 1'b0, 1'b0, 2'h3);
      h.ack();
      wt(3);
      rd(8'h00, 8'h53);
    end
    wr(8'h00, 8'h06);
    pkt(2'h2, 2'h0, 3, 1'b1, 1'b0, uer_pkg::HS_STALL);
    rd(8'h00, 8'h03);
    $display("control test done");
    wr(8'h20, 8'h00);
    wr(8'h01, 8'h09);
    pkt(2'h2, 2'h1, 9, 1'b1, 1'b0, 2'h3);
    pkt(2'h2, 2'h1, 3, 1'b1, 1'b1, uer_pkg::HS_ACK);
    rd(8'h01, 8'h18);
    rd(8'h11, 8'hc3);
    rd(8'h50, 8'ha5);
    pkt(2'h2, 2'h1, 3, 1'b1, 1'b0, uer_pkg::HS_NAK);
    wr(8'h20, 8'h10);
    pkt(2'h2, 2'h1, 3, 1'b1, 1'b0, uer_pkg::HS_NAK);
    pkt(2'h1, 2'h1, 0, 1'b0, 1'b0, 2'h3);
    wr(8'h20, 8'h02);
    wr(8'h01, 8'h09);
    pkt(2'h2, 2'h1, 3, 1'b1, 1'b0, uer_pkg::HS_STALL);
    pkt(2'h1, 2'h1, 0, 1'b0, 1'b0, 2'h3);
    rd(8'h01, 8'h09);
    $display("data out test done");
    // full 15-byte IN through a stalling host
    wr(8'h20, 8'h00);
    wr(8'h02, 8'h0d);
    load(2'h2, 4'hf);
    pkt(2'h1, 2'h2, 0, 1'b0, 1'b0, 2'h3);
    wt(100);
    h.ack();
    wt(3);
    rd(8'h02, 8'h1c);
    pkt(2'h1, 2'h2, 0, 1'b0, 1'b0, uer_pkg::HS_NAK);
    wr(8'h20, 8'h04);
    wr(8'h02, 8'h0d);
    pkt(2'h1, 2'h2, 0, 1'b0, 1'b0, uer_pkg::HS_STALL);
    rd(8'h02, 8'h0d);
    rd(8'h12, 8'h0f);
    wt(4);
    $display("data in test done");
    summarize();
  end
endmodule // tb
bind uer_responder uer_responder_chk #(.NUM_EP(NUM_EP)) chk (.mclk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tok_valid, .tok_pid, .rx_end, .rx_ok,
  .host_ack, .hs_valid, .hs_code, .tx_start, .tx_len, .tx_valid, .tx_ready, .ep_event);
